// >>> cswk_config.sv
/*
 * CAN selective wake configuration bank with its 16-bit serial slave,
 * the bit-timing counter, the wake-frame identifier comparator and the
 * time-out interrupt path.
 * Assumes every input is synchronous to core_clk, the serial clock is
 * slow enough to be oversampled, and quantumTick comes from an outside
 * divider as a one-cycle enable.
 */
`timescale 1ns/1ns

// Overview of operation
// - calibration bit 7 set enters oscillator calibration, clear keeps it off
// - unlock field 6:5 unlocks only at 11, all other values stay locked
// - unlocked and enabled calibration takes the CAN transmit pin as reference
// - wake option register writes land only while unlock field is 11
// - time-out irq enable bit 4 gates CAN time-out onto interrupt pin
// - time-out flag updates only with selective wake mode bit set
// - reserved control 3:1, sample 7:6, low-id bit 7 read zero
// - host sets valid bit 0 after checking; wake enabled only while set (wakeFrameMatch here is not gated by it)
// - valid bit clears on wake event, reset or changed configuration data
// - in Stop mode any configuration register write clears valid bit
// - first timing register gives time quanta per CAN bit
// - six-bit sample field gives sampling point as fraction below one
// - 29-bit identifier spread over four registers, low bits at 6:2
// - low-id bit 0 selects standard or extended identifier format
// - compare-top bit 1 compares identifier bit, 0 ignores it
module cswk_config #(
    parameter int QUANTA_W = 8
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic softRst,
    input wire logic spiCsN,
    input wire logic spiSclk,
    input wire logic spiSdi,
    output logic spiSdo,
    output logic spiSdoEn,
    input wire logic normalMode,
    input wire logic stopMode,
    input wire logic selectiveWakeModeEn,
    input wire logic canTimeoutEvent,
    input wire logic timeoutFlagClear,
    input wire logic wakeEvent,
    input wire logic canTxInputPin,
    input wire logic quantumTick,
    input wire logic bitSync,
    input wire logic rxFrameValid,
    input wire cswk_pkg::cswk_rx_hdr_t rxHdr,
    output logic intPinPulse,
    output logic canTimeoutFlag,
    output logic wakeConfigValid,
    output logic oscCalibMode,
    output logic trimRefActive,
    output logic trimRefSample,
    output logic altWakeRxSel,
    output logic samplePulse,
    output logic bitEndPulse,
    output logic wakeFrameMatch
);

    // the bit-timing fields are eight bits wide, nothing else is served
    if (QUANTA_W != 8) begin : gQuantaCheck
        $error("cswk_config: QUANTA_W must be 8");
    end

    // register storage
    logic [7:0] ctrl_reg;
    logic [7:0] quanta_reg;
    logic [7:0] sample_reg;
    logic [7:0] idTop_reg;
    logic [7:0] idUpper_reg;
    logic [7:0] idLower_reg;
    logic [7:0] idLowFlags_reg;
    logic [7:0] compareTop_reg;
    logic [7:0] option_reg;
    logic cfgValid_reg;

    // serial slave state
    logic sclkPrev_reg;
    logic csPrev_reg;
    logic [4:0] bitCnt_reg;
    logic [15:0] shiftIn_reg;
    logic [7:0] shiftOut_reg;
    logic sdo_reg;
    logic sdoEn_reg;
    cswk_pkg::cswk_wr_t wr;

    // derived strobes
    logic sclkRise;
    logic sclkFall;
    logic frameEnd;
    logic [6:0] peekAddr;
    logic [7:0] readData;
    logic unlocked;
    logic wakeRegWrite;
    logic cfgDataChanged;

    // edge detection on the oversampled serial clock and select
    assign sclkRise = spiSclk && !sclkPrev_reg && !spiCsN;
    assign sclkFall = !spiSclk && sclkPrev_reg && !spiCsN;
    assign frameEnd = spiCsN && !csPrev_reg;
    assign peekAddr = shiftIn_reg[15:9];

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sclkPrev_reg <= 1'b0;
            csPrev_reg <= 1'b1;
        end else begin
            sclkPrev_reg <= spiSclk;
            csPrev_reg <= spiCsN;
        end
    end

    // shift in, first bit lands lowest once the frame is complete
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            shiftIn_reg <= 16'h0000;
            bitCnt_reg <= 5'h00;
        end else if (spiCsN) begin
            bitCnt_reg <= 5'h00;
        end else if (sclkRise) begin
            shiftIn_reg <= {spiSdi, shiftIn_reg[15:1]};
            // saturate so an overlong frame is never taken as 16 bits
            if (bitCnt_reg != 5'h1f) begin
                bitCnt_reg <= bitCnt_reg + 5'h01;
            end
        end
    end

    // read data is fetched once the address is in, shifted out on falls
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            shiftOut_reg <= 8'h00;
            sdo_reg <= 1'b0;
            sdoEn_reg <= 1'b0;
        end else begin
            sdoEn_reg <= !spiCsN;
            if (spiCsN) begin
                sdo_reg <= 1'b0;
            end else if (sclkRise && bitCnt_reg == 5'h07) begin
                shiftOut_reg <= readData;
            end else if (sclkFall && bitCnt_reg >= 5'h08 && bitCnt_reg <= 5'h0f) begin
                sdo_reg <= shiftOut_reg[0];
                shiftOut_reg <= {1'b0, shiftOut_reg[7:1]};
            end
        end
    end

    // a write is committed only by a frame of exactly sixteen bits
    always_comb begin
        wr.strobe = frameEnd && bitCnt_reg == 5'(cswk_pkg::FRAME_BITS)
            && shiftIn_reg[cswk_pkg::FRAME_RW_BIT];
        wr.addr = shiftIn_reg[6:0];
        wr.data = shiftIn_reg[15:cswk_pkg::FRAME_DATA_LO];
    end

    // readback; peekAddr holds the whole address only at the eighth rise
    always_comb begin
        if (peekAddr == cswk_pkg::ADDR_CTRL) begin
            readData = {ctrl_reg[7:4], 3'b000, cfgValid_reg};
        end else if (peekAddr == cswk_pkg::ADDR_TIMING_QUANTA) begin
            readData = quanta_reg;
        end else if (peekAddr == cswk_pkg::ADDR_TIMING_SAMPLE) begin
            readData = sample_reg & cswk_pkg::SAMPLE_WRITE_MASK;
        end else if (peekAddr == cswk_pkg::ADDR_ID_TOP) begin
            readData = idTop_reg;
        end else if (peekAddr == cswk_pkg::ADDR_ID_UPPER) begin
            readData = idUpper_reg;
        end else if (peekAddr == cswk_pkg::ADDR_ID_LOWER) begin
            readData = idLower_reg;
        end else if (peekAddr == cswk_pkg::ADDR_ID_LOW_FLAGS) begin
            readData = idLowFlags_reg & cswk_pkg::ID_LOW_WRITE_MASK;
        end else if (peekAddr == cswk_pkg::ADDR_COMPARE_TOP) begin
            readData = compareTop_reg;
        end else if (peekAddr == cswk_pkg::ADDR_WAKE_OPTION) begin
            readData = option_reg;
        end else begin
            readData = 8'h00;
        end
    end

    assign unlocked = ctrl_reg[cswk_pkg::CTRL_UNLOCK_HI:cswk_pkg::CTRL_UNLOCK_LO]
        == cswk_pkg::UNLOCK_KEY;

    // any write into the bank, option register included
    assign wakeRegWrite = wr.strobe && ((wr.addr >= cswk_pkg::ADDR_CTRL
        && wr.addr <= cswk_pkg::ADDR_COMPARE_TOP) || wr.addr == cswk_pkg::ADDR_WAKE_OPTION);

    // a write that really alters stored configuration data
    always_comb begin
        cfgDataChanged = 1'b0;
        if (wr.strobe) begin
            if (wr.addr == cswk_pkg::ADDR_TIMING_QUANTA) begin
                cfgDataChanged = wr.data != quanta_reg;
            end else if (wr.addr == cswk_pkg::ADDR_TIMING_SAMPLE) begin
                cfgDataChanged = (wr.data & cswk_pkg::SAMPLE_WRITE_MASK) != sample_reg;
            end else if (wr.addr == cswk_pkg::ADDR_ID_TOP) begin
                cfgDataChanged = wr.data != idTop_reg;
            end else if (wr.addr == cswk_pkg::ADDR_ID_UPPER) begin
                cfgDataChanged = wr.data != idUpper_reg;
            end else if (wr.addr == cswk_pkg::ADDR_ID_LOWER) begin
                cfgDataChanged = wr.data != idLower_reg;
            end else if (wr.addr == cswk_pkg::ADDR_ID_LOW_FLAGS) begin
                cfgDataChanged = (wr.data & cswk_pkg::ID_LOW_WRITE_MASK) != idLowFlags_reg;
            end else if (wr.addr == cswk_pkg::ADDR_COMPARE_TOP) begin
                cfgDataChanged = wr.data != compareTop_reg;
            end else if (wr.addr == cswk_pkg::ADDR_WAKE_OPTION && unlocked) begin
                cfgDataChanged = wr.data != option_reg;
            end
        end
    end

    // configuration registers; soft reset restores the reset values
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ctrl_reg <= cswk_pkg::RST_CTRL;
            quanta_reg <= cswk_pkg::RST_TIMING_QUANTA;
            sample_reg <= cswk_pkg::RST_TIMING_SAMPLE;
            idTop_reg <= cswk_pkg::RST_ID;
            idUpper_reg <= cswk_pkg::RST_ID;
            idLower_reg <= cswk_pkg::RST_ID;
            idLowFlags_reg <= cswk_pkg::RST_ID;
            compareTop_reg <= cswk_pkg::RST_COMPARE;
        end else if (softRst) begin
            ctrl_reg <= cswk_pkg::RST_CTRL;
            quanta_reg <= cswk_pkg::RST_TIMING_QUANTA;
            sample_reg <= cswk_pkg::RST_TIMING_SAMPLE;
            idTop_reg <= cswk_pkg::RST_ID;
            idUpper_reg <= cswk_pkg::RST_ID;
            idLower_reg <= cswk_pkg::RST_ID;
            idLowFlags_reg <= cswk_pkg::RST_ID;
            compareTop_reg <= cswk_pkg::RST_COMPARE;
        end else if (wr.strobe) begin
            if (wr.addr == cswk_pkg::ADDR_CTRL) begin
                ctrl_reg <= wr.data & cswk_pkg::CTRL_WRITE_MASK;
            end else if (wr.addr == cswk_pkg::ADDR_TIMING_QUANTA) begin
                quanta_reg <= wr.data;
            end else if (wr.addr == cswk_pkg::ADDR_TIMING_SAMPLE) begin
                sample_reg <= wr.data & cswk_pkg::SAMPLE_WRITE_MASK;
            end else if (wr.addr == cswk_pkg::ADDR_ID_TOP) begin
                idTop_reg <= wr.data;
            end else if (wr.addr == cswk_pkg::ADDR_ID_UPPER) begin
                idUpper_reg <= wr.data;
            end else if (wr.addr == cswk_pkg::ADDR_ID_LOWER) begin
                idLower_reg <= wr.data;
            end else if (wr.addr == cswk_pkg::ADDR_ID_LOW_FLAGS) begin
                idLowFlags_reg <= wr.data & cswk_pkg::ID_LOW_WRITE_MASK;
            end else if (wr.addr == cswk_pkg::ADDR_COMPARE_TOP) begin
                compareTop_reg <= wr.data;
            end
        end
    end

    // option register guarded by the unlock key
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            option_reg <= cswk_pkg::RST_OPTION;
        end else if (softRst) begin
            option_reg <= cswk_pkg::RST_OPTION;
        end else if (wr.strobe && wr.addr == cswk_pkg::ADDR_WAKE_OPTION && unlocked) begin
            option_reg <= wr.data;
        end
    end

    // valid flag: every clear cause outranks the host setting it
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cfgValid_reg <= 1'b0;
        end else if (softRst || wakeEvent || cfgDataChanged) begin
            cfgValid_reg <= 1'b0;
        end else if (stopMode && wakeRegWrite) begin
            cfgValid_reg <= 1'b0;
        end else if (wr.strobe && wr.addr == cswk_pkg::ADDR_CTRL) begin
            cfgValid_reg <= wr.data[cswk_pkg::CTRL_VALID_BIT];
        end
    end

    // time-out flag; a new event wins over a clear in the same cycle
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            canTimeoutFlag <= 1'b0;
        end else if (canTimeoutEvent && selectiveWakeModeEn) begin
            canTimeoutFlag <= 1'b1;
        end else if (timeoutFlagClear) begin
            canTimeoutFlag <= 1'b0;
        end
    end

    // interrupt pulse only from a time-out that actually updates the flag
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            intPinPulse <= 1'b0;
        end else begin
            intPinPulse <= canTimeoutEvent && selectiveWakeModeEn
                && (normalMode || stopMode) && ctrl_reg[cswk_pkg::CTRL_TIMEOUT_IRQ_BIT];
        end
    end

    // oscillator calibration outputs, reference sampled from the tx pin
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            oscCalibMode <= 1'b0;
            trimRefActive <= 1'b0;
            trimRefSample <= 1'b0;
        end else begin
            oscCalibMode <= ctrl_reg[cswk_pkg::CTRL_OSC_CALIB_BIT];
            trimRefActive <= ctrl_reg[cswk_pkg::CTRL_OSC_CALIB_BIT] && unlocked;
            trimRefSample <= ctrl_reg[cswk_pkg::CTRL_OSC_CALIB_BIT] && unlocked && canTxInputPin;
        end
    end

    // plain registered copies of state for the rest of the chip
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wakeConfigValid <= 1'b0;
            altWakeRxSel <= 1'b0;
        end else begin
            wakeConfigValid <= cfgValid_reg;
            altWakeRxSel <= option_reg[0];
        end
    end

    assign spiSdo = sdo_reg;
    assign spiSdoEn = sdoEn_reg;

    // bit-timing counter; a zero quanta setting simply runs 256 quanta
    logic [QUANTA_W-1:0] quantaCnt_reg;
    logic [QUANTA_W+5:0] sampleProduct;
    logic [QUANTA_W-1:0] samplePos;

    // position is quanta times field over 64
    assign sampleProduct = quanta_reg * sample_reg[cswk_pkg::SAMPLE_FRAC_BITS-1:0];
    assign samplePos = sampleProduct[QUANTA_W+5:cswk_pkg::SAMPLE_FRAC_BITS];

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            quantaCnt_reg <= '0;
            samplePulse <= 1'b0;
            bitEndPulse <= 1'b0;
        end else begin
            samplePulse <= 1'b0;
            bitEndPulse <= 1'b0;
            if (bitSync) begin
                quantaCnt_reg <= '0;
            end else if (quantumTick) begin
                samplePulse <= quantaCnt_reg == samplePos;
                if (quantaCnt_reg == quanta_reg - 8'h01) begin
                    quantaCnt_reg <= '0;
                    bitEndPulse <= 1'b1;
                end else begin
                    quantaCnt_reg <= quantaCnt_reg + 8'h01;
                end
            end
        end
    end

    // identifier comparator
    logic [28:0] cfgId;
    logic [28:0] compareMask;
    logic idMatch;

    assign cfgId = {idTop_reg, idUpper_reg, idLower_reg,
        idLowFlags_reg[cswk_pkg::ID_LOW_ID_HI:cswk_pkg::ID_LOW_ID_LO]};
    assign compareMask = {compareTop_reg, idLowFlags_reg[cswk_pkg::ID_LOW_IDE_BIT]
        ? cswk_pkg::EXT_LOW_COMPARE : cswk_pkg::STD_LOW_COMPARE};

    always_comb begin
        idMatch = 1'b1;
        for (int i = 0; i < 29; i++) begin
            if (compareMask[i] && rxHdr.id[i] != cfgId[i]) begin
                idMatch = 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wakeFrameMatch <= 1'b0;
        end else begin
            wakeFrameMatch <= rxFrameValid && idMatch
                && rxHdr.ide == idLowFlags_reg[cswk_pkg::ID_LOW_IDE_BIT]
                && rxHdr.rtr == idLowFlags_reg[cswk_pkg::ID_LOW_RTR_BIT];
        end
    end

endmodule : cswk_config

// >>> cswk_pkg.sv
/*
 * Package for the CAN selective wake configuration bank: register
 * addresses, field positions, reset values and the carrier types.
 * Assumes a 7-bit register address and 8-bit registers on a 16-bit
 * serial frame.
 */
package cswk_pkg;

    // register addresses (7-bit serial address space)
    localparam logic [6:0] ADDR_CTRL = 7'h20;
    localparam logic [6:0] ADDR_TIMING_QUANTA = 7'h21;
    localparam logic [6:0] ADDR_TIMING_SAMPLE = 7'h22;
    localparam logic [6:0] ADDR_ID_TOP = 7'h23;
    localparam logic [6:0] ADDR_ID_UPPER = 7'h24;
    localparam logic [6:0] ADDR_ID_LOWER = 7'h25;
    localparam logic [6:0] ADDR_ID_LOW_FLAGS = 7'h26;
    localparam logic [6:0] ADDR_COMPARE_TOP = 7'h27;
    localparam logic [6:0] ADDR_WAKE_OPTION = 7'h35;

    // control register fields
    localparam int CTRL_OSC_CALIB_BIT = 7;
    localparam int CTRL_UNLOCK_HI = 6;
    localparam int CTRL_UNLOCK_LO = 5;
    localparam int CTRL_TIMEOUT_IRQ_BIT = 4;
    localparam int CTRL_VALID_BIT = 0;
    localparam logic [1:0] UNLOCK_KEY = 2'h3;
    localparam logic [7:0] CTRL_WRITE_MASK = 8'hf1;

    // bit-timing and identifier fields
    localparam logic [7:0] SAMPLE_WRITE_MASK = 8'h3f;
    localparam logic [7:0] ID_LOW_WRITE_MASK = 8'h7f;
    localparam int ID_LOW_ID_HI = 6;
    localparam int ID_LOW_ID_LO = 2;
    localparam int ID_LOW_RTR_BIT = 1;
    localparam int ID_LOW_IDE_BIT = 0;
    localparam int SAMPLE_FRAC_BITS = 6;
    localparam logic [20:0] STD_LOW_COMPARE = 21'h1c_0000;
    localparam logic [20:0] EXT_LOW_COMPARE = 21'h1f_ffff;

    // reset values
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [7:0] RST_TIMING_QUANTA = 8'ha0;
    localparam logic [7:0] RST_TIMING_SAMPLE = 8'h33;
    localparam logic [7:0] RST_ID = 8'h00;
    localparam logic [7:0] RST_COMPARE = 8'h00;
    localparam logic [7:0] RST_OPTION = 8'h00;

    // serial frame layout, first bit on the wire is bit 0
    localparam int FRAME_BITS = 16;
    localparam int FRAME_RW_BIT = 7;
    localparam int FRAME_DATA_LO = 8;

    // a received frame header presented by the receiver datapath
    typedef struct packed {
        logic [28:0] id;
        logic ide;
        logic rtr;
    } cswk_rx_hdr_t;

    // a decoded register write
    typedef struct packed {
        logic strobe;
        logic [6:0] addr;
        logic [7:0] data;
    } cswk_wr_t;

endpackage : cswk_pkg

// >>> cswk_config_assertions.sv
/* checker for the selective wake configuration bank, bound to its ports.
   assumes one clock domain and a reset that clears every output. */
`timescale 1ns/1ns
module cswk_config_assertions (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic softRst,
    input wire logic normalMode,
    input wire logic stopMode,
    input wire logic selectiveWakeModeEn,
    input wire logic canTimeoutEvent,
    input wire logic timeoutFlagClear,
    input wire logic wakeEvent,
    input wire logic canTxInputPin,
    input wire logic quantumTick,
    input wire logic rxFrameValid,
    input wire logic intPinPulse,
    input wire logic canTimeoutFlag,
    input wire logic wakeConfigValid,
    input wire logic oscCalibMode,
    input wire logic trimRefActive,
    input wire logic trimRefSample,
    input wire logic samplePulse,
    input wire logic bitEndPulse,
    input wire logic wakeFrameMatch
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // a time-out only counts while selective wake mode is on
    sequence s_timeout;
        canTimeoutEvent && selectiveWakeModeEn;
    endsequence
    // the valid output trails the internal bit by one cycle
    sequence s_lag_low;
        ##2 !wakeConfigValid;
    endsequence
    AST_FLAG_SET: assert property (s_timeout |=> canTimeoutFlag)
        else $error("time-out flag not set");
    AST_FLAG_HOLD: assert property (canTimeoutFlag && !timeoutFlagClear
        |=> canTimeoutFlag) else $error("time-out flag dropped without clear");
    AST_FLAG_CAUSE: assert property ($rose(canTimeoutFlag) |-> $past(canTimeoutEvent)
        && $past(selectiveWakeModeEn)) else $error("time-out flag set without cause");
    AST_IRQ_CAUSE: assert property (intPinPulse |->
        $past(canTimeoutEvent && selectiveWakeModeEn && (normalMode || stopMode)))
        else $error("interrupt without qualified time-out");
    AST_VALID_DROP: assert property ((wakeEvent || softRst) |-> s_lag_low)
        else $error("valid bit survived wake or soft reset");
    AST_VALID_SET: assert property ($rose(wakeConfigValid) |->
        !$past(stopMode, 2) && !$past(wakeEvent, 2) && !$past(softRst, 2))
        else $error("valid bit set against a clearing cause");
    AST_TRIM_PIN: assert property (trimRefSample |-> trimRefActive && oscCalibMode
        && $past(canTxInputPin)) else $error("trim reference without unlock");
    AST_MATCH_CAUSE: assert property (wakeFrameMatch |-> $past(rxFrameValid))
        else $error("match without received frame");
    AST_TICK: assert property ((samplePulse || bitEndPulse) |-> $past(quantumTick))
        else $error("timing pulse without quantum tick");
endmodule : cswk_config_assertions

bind cswk_config cswk_config_assertions u_cswk_config_assertions (.core_clk, .rst, .softRst,
    .normalMode, .stopMode, .selectiveWakeModeEn, .canTimeoutEvent, .timeoutFlagClear,
    .wakeEvent, .canTxInputPin, .quantumTick, .rxFrameValid, .intPinPulse, .canTimeoutFlag,
    .wakeConfigValid, .oscCalibMode, .trimRefActive, .trimRefSample, .samplePulse,
    .bitEndPulse, .wakeFrameMatch);

// >>> cswk_host_model.sv
/* host serial master: frames of address, write bit and data, lsb first.
   assumes the device oversamples the serial clock with core_clk. */
`timescale 1ns/1ns
module cswk_host_model (
    input wire logic core_clk,
    output logic spiCsN,
    output logic spiSclk,
    output logic spiSdi,
    input wire logic spiSdo
);
    // idle: deselected, clock low
    initial begin
        spiCsN = 1'b1;
        spiSclk = 1'b0;
        spiSdi = 1'b0;
    end
    // two core cycles per clock phase; read bits taken just before rises 9 to 16
    task automatic xfer(input logic [15:0] f, input int n, output logic [7:0] r);
        r = 8'h00;
        @(negedge core_clk) spiCsN = 1'b0;
        for (int i = 0; i < n; i++) begin
            spiSdi = f[i];
            repeat (2) @(negedge core_clk);
            if (i > 7) r[i-8] = spiSdo;
            spiSclk = 1'b1;
            repeat (2) @(negedge core_clk);
            spiSclk = 1'b0;
        end
        repeat (2) @(negedge core_clk);
        spiCsN = 1'b1;
        spiSdi = ~spiSdi; // released line must not keep the last bit
        repeat (3) @(negedge core_clk);
    endtask : xfer
endmodule : cswk_host_model

// >>> cswk_config_tb.sv
/* testbench for the selective wake configuration bank with a reference model.
   assumes package, design, host model and checker are compiled before it. */
`timescale 1ns/1ns
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin bad_count++; \
    $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module cswk_config_tb;
    logic core_clk, rst, softRst, spiCsN, spiSclk, spiSdi, spiSdo, spiSdoEn, normalMode, stopMode;
    logic selectiveWakeModeEn, canTimeoutEvent, timeoutFlagClear, wakeEvent, canTxInputPin;
    logic quantumTick, bitSync, rxFrameValid, intPinPulse, canTimeoutFlag, wakeConfigValid;
    logic oscCalibMode, trimRefActive, trimRefSample, altWakeRxSel, samplePulse, bitEndPulse;
    logic wakeFrameMatch, ide;
    cswk_pkg::cswk_rx_hdr_t rxHdr;
    logic [31:0] seed = 32'h28c4_43e2;
    logic [28:0] id, mask;
    logic [7:0] v, top;
    int bad_count, checks_done, irqCount, cyc, lastBe, beGap, spOff, q, s, n0, expv[8];
    int rv[8] = '{8'h00, 8'ha0, 8'h33, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    int wm[8] = '{8'hf1, 8'hff, 8'h3f, 8'hff, 8'hff, 8'hff, 8'h7f, 8'hff};
    cswk_config #(.QUANTA_W(8)) u_cswk_config (.core_clk, .rst, .softRst, .spiCsN, .spiSclk,
        .spiSdi, .spiSdo, .spiSdoEn, .normalMode, .stopMode, .selectiveWakeModeEn,
        .canTimeoutEvent, .timeoutFlagClear, .wakeEvent, .canTxInputPin, .quantumTick, .bitSync,
        .rxFrameValid, .rxHdr, .intPinPulse, .canTimeoutFlag, .wakeConfigValid, .oscCalibMode,
        .trimRefActive, .trimRefSample, .altWakeRxSel, .samplePulse, .bitEndPulse,
        .wakeFrameMatch);
    cswk_host_model u_cswk_host_model (.core_clk, .spiCsN, .spiSclk, .spiSdi, .spiSdo);
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr
    // one register access; the model keeps what a write should leave behind
    task automatic acc(input int a, input int w, input int d, output logic [7:0] r);
        u_cswk_host_model.xfer({8'(d), 1'(w), 7'(a)}, 16, r);
        if (w != 0 && a > 8'h20 && a < 8'h28) expv[a-8'h20] = d & wm[a-8'h20];
        repeat (2) @(negedge core_clk);
    endtask : acc
    task automatic pulse(ref logic p);
        @(negedge core_clk) p = 1'b1;
        @(negedge core_clk) p = 1'b0;
    endtask : pulse
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : report_and_stop
    // 50 MHz core clock
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    // counts interrupts and measures timing pulse spacing
    always @(posedge core_clk) begin
        cyc++;
        if (intPinPulse === 1'b1) irqCount++;
        if (samplePulse === 1'b1) spOff = cyc - lastBe;
        if (bitEndPulse === 1'b1) begin
            beGap = cyc - lastBe;
            lastBe = cyc;
        end
    end
    // hang guard, well beyond the expected run
    initial begin
        repeat (20000) @(posedge core_clk);
        bad_count++;
        report_and_stop();
    end
    initial begin
        {rst, softRst, normalMode, stopMode, selectiveWakeModeEn, canTimeoutEvent,
        timeoutFlagClear, wakeEvent, canTxInputPin, quantumTick, bitSync, rxFrameValid} = 12'h800;
        rxHdr = '0;
        repeat (3) @(negedge core_clk);
        rst = 1'b0;
        repeat (2) @(negedge core_clk);
        // reset values, then random contents; 0x28 is outside the bank
        for (int a = 0; a < 9; a++) begin
            acc(8'h20 + a, 0, 0, v);
            `CHK("reset value", (a < 8) ? rv[a] : 0, v)
        end
        for (int a = 1; a < 9; a++) begin
            seed = lfsr(seed);
            acc(8'h20 + a, 1, (a == 6) ? seed[7:0] & 8'hfd : seed[7:0], v);
        end
        for (int a = 1; a < 9; a++) begin
            acc(8'h20 + a, 0, 0, v);
            `CHK("register", (a < 8) ? expv[a] : 0, v)
        end
        // valid bit: changed data, stop-mode write, wake, soft reset each clear it
        for (int k = 0; k < 4; k++) begin
            acc(8'h20, 1, 8'h01, v);
            `CHK("valid set", 1, wakeConfigValid)
            stopMode = (k == 1);
            case (k)
                0: acc(8'h24, 1, expv[4] ^ 8'hff, v);
                1: acc(8'h26, 1, expv[6], v);
                2: pulse(wakeEvent);
                default: pulse(softRst);
            endcase
            repeat (2) @(negedge core_clk);
            stopMode = 1'b0;
            `CHK("valid cleared", 0, wakeConfigValid)
        end
        acc(8'h21, 0, 0, v);
        `CHK("soft reset", 8'ha0, v)
        // every unlock key against calibration, trim reference and option write
        for (int k = 0; k < 4; k++) begin
            acc(8'h20, 1, 8'h80 | (k << 5), v);
            acc(8'h35, 1, 8'h01, v);
            seed = lfsr(seed);
            canTxInputPin = seed[0];
            repeat (2) @(negedge core_clk);
            `CHK("calib", 1, oscCalibMode)
            `CHK("trim", k == 3, trimRefActive)
            `CHK("trim ref", (k == 3) & seed[0], trimRefSample)
            `CHK("option", k == 3, altWakeRxSel)
        end
        // time-out against irq enable and selective wake mode
        normalMode = 1'b1;
        for (int m = 0; m < 4; m++) begin
            acc(8'h20, 1, m[0] ? 8'h10 : 8'h00, v);
            selectiveWakeModeEn = m[1];
            n0 = irqCount;
            pulse(timeoutFlagClear);
            pulse(canTimeoutEvent);
            @(negedge core_clk);
            `CHK("calib off", 0, oscCalibMode)
            `CHK("irq", m == 3, irqCount - n0)
            `CHK("flag", m[1], canTimeoutFlag)
        end
        // identifier compare, standard then extended, single-bit flips
        for (int j = 0; j < 24; j++) begin
            seed = lfsr(seed);
            if (j % 12 == 0) begin
                ide = (j > 0);
                id = ide ? seed[28:0] : seed[28:0] & 29'h1ffc_0000;
                top = seed[31:24];
                acc(8'h23, 1, id[28:21], v);
                acc(8'h24, 1, id[20:13], v);
                acc(8'h25, 1, id[12:5], v);
                acc(8'h26, 1, {id[4:0], 1'b0, ide}, v);
                acc(8'h27, 1, top, v);
            end
            rxHdr.id = id ^ ((j % 3 == 0) ? 29'h0 : 29'h1 << (seed[12:8] % 29));
            rxHdr.rtr = (j % 12 == 5);
            rxHdr.ide = ide ^ (j % 12 == 7);
            mask = {top, ide ? 21'h1f_ffff : 21'h1c_0000} & (rxHdr.id ^ id);
            pulse(rxFrameValid);
            `CHK("match", !mask && rxHdr.ide == ide && !rxHdr.rtr, wakeFrameMatch)
        end
        // bit period and sample offset in quanta
        seed = lfsr(seed);
        q = 16 + seed[4:0];
        s = seed[13:8];
        acc(8'h21, 1, q, v);
        acc(8'h22, 1, s, v);
        quantumTick = 1'b1;
        pulse(bitSync);
        repeat (3 * q) @(negedge core_clk);
        `CHK("bit period", q, beGap)
        `CHK("sample offset", ((q * s) >> 6) + 1, spOff)
        report_and_stop();
    end
endmodule : cswk_config_tb
